// ---- core/cfd_diag_filter.sv ----
// Purpose: Bus diagnostics status word and filter control map
// Assumes: Event and bit-observation inputs come from logic on mclk
// Notes: Level 1 is recessive on both driven and sampled levels
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

module cfd_diag_filter #(
    parameter int NUM_FLT = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [cfd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire cfd_pkg::cfd_bit_t bit_obs,
    input wire cfd_pkg::cfd_evt_t err_evt,
    output logic [NUM_FLT-1:0] filter_accept_enable,
    output logic [NUM_FLT-1:0][cfd_pkg::PTR_W-1:0] filter_target_object
);
    logic [15:0] flags_reg;
    logic [15:0] flags_next;
    logic [15:0] set_vec;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [3:0] run_reg;
    logic [3:0] run_next;
    logic [NUM_FLT-1:0] en_reg;
    logic [NUM_FLT-1:0][cfd_pkg::PTR_W-1:0] ptr_reg;
    logic [31:0] rdata_next;
    logic [31:0] diag_word;
    logic [31:0] flt_word [0:1];
    logic dom_miss;
    logic rec_miss;
    logic recov_hit;
    logic diag_access;

    assign diag_access = (reg_rd | reg_wr) && reg_addr == cfd_pkg::OFS_DIAG;

    // Bit monitor: driven level against sampled level
    assign dom_miss = bit_obs.bit_valid & bit_obs.tx_active
        & ~bit_obs.driven_level & bit_obs.sampled_level;
    assign rec_miss = bit_obs.bit_valid & bit_obs.tx_active & ~bit_obs.arbitration
        & bit_obs.driven_level & ~bit_obs.sampled_level;

    // Recessive run during bus-off recovery
    always_comb begin
        run_next = run_reg;
        if (!bit_obs.busoff_recovery) begin
            run_next = 4'h0;
        end else if (bit_obs.bit_valid) begin
            if (!bit_obs.sampled_level) begin
                run_next = 4'h0;
            end else if (run_reg == cfd_pkg::RECOV_RUN - 4'h1) begin
                run_next = 4'h0;
            end else begin
                run_next = run_reg + 4'h1;
            end
        end
    end

    assign recov_hit = bit_obs.busoff_recovery & bit_obs.bit_valid & bit_obs.sampled_level
        & (run_reg == cfd_pkg::RECOV_RUN - 4'h1);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            run_reg <= 4'h0;
        end else begin
            run_reg <= run_next;
        end
    end

    // Flag set vector, aligned to bits 31..16
    always_comb begin
        set_vec = 16'h0000;
        set_vec[cfd_pkg::POS_LEN_MISMATCH-16] = err_evt.length_code_mismatch;
        set_vec[cfd_pkg::POS_ESI-16] = err_evt.esi_received;
        set_vec[cfd_pkg::POS_DATA_CRC-16] = err_evt.data_crc_fail;
        set_vec[cfd_pkg::POS_DATA_STUFF-16] = err_evt.data_stuffing_fail;
        set_vec[cfd_pkg::POS_DATA_FORM-16] = err_evt.data_form_fail;
        set_vec[cfd_pkg::POS_DATA_REC-16] = rec_miss & bit_obs.data_phase;
        set_vec[cfd_pkg::POS_DATA_DOM-16] = (dom_miss & bit_obs.data_phase) | recov_hit;
        set_vec[cfd_pkg::POS_TX_BUSOFF-16] = err_evt.tx_busoff_recovered;
        set_vec[cfd_pkg::POS_NOM_CRC-16] = err_evt.nominal_crc_fail;
        set_vec[cfd_pkg::POS_NOM_STUFF-16] = err_evt.nominal_stuffing_fail;
        set_vec[cfd_pkg::POS_NOM_FORM-16] = err_evt.nominal_form_fail;
        set_vec[cfd_pkg::POS_ACK-16] = err_evt.ack_missing;
        set_vec[cfd_pkg::POS_NOM_REC-16] = rec_miss & ~bit_obs.data_phase;
        set_vec[cfd_pkg::POS_NOM_DOM-16] = (dom_miss & ~bit_obs.data_phase) | recov_hit;
    end

    // Sticky flags; a set in the clearing cycle survives
    always_comb begin
        flags_next = diag_access ? 16'h0000 : flags_reg;
        flags_next = (flags_next | set_vec) & cfd_pkg::FLAG_MASK;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flags_reg <= cfd_pkg::DIAG_RESET[31:16];
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Clean message counter, saturating at full scale
    always_comb begin
        cnt_next = diag_access ? 16'h0000 : cnt_reg;
        if (err_evt.clean_message && cnt_next != cfd_pkg::CNT_MAX) begin
            cnt_next = cnt_next + 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_reg <= cfd_pkg::DIAG_RESET[15:0];
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Filter lanes: enable always writable, pointer only while disabled
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            en_reg <= '0;
            ptr_reg <= '0;
        end else if (reg_wr) begin
            for (int i = 0; i < NUM_FLT; i++) begin
                if (reg_addr == (i < cfd_pkg::FLT_PER_REG ? cfd_pkg::OFS_FLT0
                        : cfd_pkg::OFS_FLT1)) begin
                    en_reg[i] <= reg_wdata[8*(i%4)+cfd_pkg::FLT_EN_POS];
                    if (!en_reg[i]) begin
                        ptr_reg[i] <= reg_wdata[8*(i%4) +: cfd_pkg::PTR_W];
                    end
                end
            end
        end
    end

    assign filter_accept_enable = en_reg;
    assign filter_target_object = ptr_reg;

    // Read mux; reserved bits fixed at zero
    always_comb begin
        diag_word = {flags_reg & cfd_pkg::FLAG_MASK, cnt_reg};
        flt_word[0] = 32'h0000_0000;
        flt_word[1] = 32'h0000_0000;
        for (int i = 0; i < NUM_FLT; i++) begin
            flt_word[i/4][8*(i%4)+cfd_pkg::FLT_EN_POS] = en_reg[i];
            flt_word[i/4][8*(i%4) +: cfd_pkg::PTR_W] = ptr_reg[i];
        end
        unique case (reg_addr)
            cfd_pkg::OFS_DIAG: rdata_next = diag_word;
            cfd_pkg::OFS_FLT0: rdata_next = flt_word[0];
            cfd_pkg::OFS_FLT1: rdata_next = flt_word[1];
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    a_read_clears_flags: assert property (
        diag_access && set_vec == 16'h0000 |=> flags_reg == 16'h0000)
        else $error("flags not cleared by access");

    a_set_beats_clear: assert property (
        diag_access && set_vec != 16'h0000
        |=> (flags_reg & $past(set_vec & cfd_pkg::FLAG_MASK))
            == $past(set_vec & cfd_pkg::FLAG_MASK))
        else $error("same-cycle error lost on clear");

    a_read_old_word: assert property (
        reg_rd && reg_addr == cfd_pkg::OFS_DIAG |=> reg_rdata == $past(diag_word))
        else $error("clearing read returned wrong word");

    a_count_clear: assert property (
        diag_access && !err_evt.clean_message |=> cnt_reg == 16'h0000)
        else $error("counter not cleared");

    a_count_step: assert property (
        !diag_access && err_evt.clean_message && cnt_reg != cfd_pkg::CNT_MAX
        |=> cnt_reg == $past(cnt_reg) + 16'h0001)
        else $error("counter did not step");

    a_recovery_run: assert property (
        bit_obs.busoff_recovery && bit_obs.bit_valid && bit_obs.sampled_level
        && run_reg == cfd_pkg::RECOV_RUN - 4'h1 |=> flags_reg[cfd_pkg::POS_NOM_DOM-16]
        && flags_reg[cfd_pkg::POS_DATA_DOM-16])
        else $error("recovery run did not set bit-0 flags");

    a_data_dom_miss: assert property (
        dom_miss && bit_obs.data_phase |=> flags_reg[cfd_pkg::POS_DATA_DOM-16])
        else $error("data dominant miss not flagged");

    a_nom_rec_miss: assert property (
        bit_obs.bit_valid && bit_obs.arbitration && !bit_obs.data_phase
        && !flags_reg[cfd_pkg::POS_NOM_REC-16] |=> !flags_reg[cfd_pkg::POS_NOM_REC-16])
        else $error("recessive miss flagged in arbitration");

    a_ptr_locked: assert property (
        reg_wr && reg_addr == cfd_pkg::OFS_FLT0 && en_reg[0] |=> $stable(ptr_reg[0]))
        else $error("pointer changed while enabled");

    a_reserved_zero: assert property (
        $past(reg_rd) |-> ($past(reg_addr) == cfd_pkg::OFS_DIAG)
        ? (reg_rdata[26] == 1'b0 && reg_rdata[22] == 1'b0)
        : ((reg_rdata & 32'h6060_6060) == 32'h0000_0000))
        else $error("reserved bit reads nonzero");

    a_len_mismatch: assert property (
        err_evt.length_code_mismatch
        |=> flags_reg[cfd_pkg::POS_LEN_MISMATCH-16])
        else $error("length code mismatch not flagged");

    a_esi_seen: assert property (
        err_evt.esi_received
        |=> flags_reg[cfd_pkg::POS_ESI-16])
        else $error("received ESI not flagged");

    a_data_crc: assert property (
        err_evt.data_crc_fail
        |=> flags_reg[cfd_pkg::POS_DATA_CRC-16])
        else $error("data CRC error not flagged");

    a_data_stuff: assert property (
        err_evt.data_stuffing_fail
        |=> flags_reg[cfd_pkg::POS_DATA_STUFF-16])
        else $error("data stuffing error not flagged");

    a_data_form: assert property (
        err_evt.data_form_fail
        |=> flags_reg[cfd_pkg::POS_DATA_FORM-16])
        else $error("data format error not flagged");

    a_busoff_flag: assert property (
        err_evt.tx_busoff_recovered
        |=> flags_reg[cfd_pkg::POS_TX_BUSOFF-16])
        else $error("bus-off recovery not flagged");

    a_nom_crc: assert property (
        err_evt.nominal_crc_fail
        |=> flags_reg[cfd_pkg::POS_NOM_CRC-16])
        else $error("nominal CRC error not flagged");

    a_nom_stuff: assert property (
        err_evt.nominal_stuffing_fail
        |=> flags_reg[cfd_pkg::POS_NOM_STUFF-16])
        else $error("nominal stuffing error not flagged");

    a_nom_form: assert property (
        err_evt.nominal_form_fail
        |=> flags_reg[cfd_pkg::POS_NOM_FORM-16])
        else $error("nominal format error not flagged");

    a_ack_missing: assert property (
        err_evt.ack_missing
        |=> flags_reg[cfd_pkg::POS_ACK-16])
        else $error("missing acknowledge not flagged");

    a_nom_dom_miss: assert property (
        dom_miss && !bit_obs.data_phase
        |=> flags_reg[cfd_pkg::POS_NOM_DOM-16])
        else $error("nominal dominant miss not flagged");

    a_data_rec_miss: assert property (
        rec_miss && bit_obs.data_phase
        |=> flags_reg[cfd_pkg::POS_DATA_REC-16])
        else $error("data recessive miss not flagged");

    a_nom_rec_set: assert property (
        rec_miss && !bit_obs.data_phase
        |=> flags_reg[cfd_pkg::POS_NOM_REC-16])
        else $error("nominal recessive miss not flagged");

    a_phase_split: assert property (
        dom_miss && bit_obs.data_phase && !recov_hit && !flags_reg[cfd_pkg::POS_NOM_DOM-16]
        |=> !flags_reg[cfd_pkg::POS_NOM_DOM-16])
        else $error("data phase miss set nominal flag");

    a_flags_sticky: assert property (
        !diag_access && flags_reg != 16'h0000
        |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
        else $error("flag dropped without access");

    a_count_hold: assert property (
        !diag_access && !err_evt.clean_message
        |=> $stable(cnt_reg))
        else $error("counter moved without message");

    a_count_saturate: assert property (
        !diag_access && cnt_reg == cfd_pkg::CNT_MAX
        |=> cnt_reg == cfd_pkg::CNT_MAX)
        else $error("counter wrapped past full scale");

    a_run_restart: assert property (
        bit_obs.busoff_recovery && bit_obs.bit_valid && !bit_obs.sampled_level
        |=> run_reg == 4'h0)
        else $error("dominant bit did not restart run");

    a_run_step: assert property (
        bit_obs.busoff_recovery && bit_obs.bit_valid && bit_obs.sampled_level
        && run_reg != cfd_pkg::RECOV_RUN - 4'h1 |=> run_reg == $past(run_reg) + 4'h1)
        else $error("recessive bit did not extend run");

    a_enable_write: assert property (
        reg_wr && reg_addr == cfd_pkg::OFS_FLT0
        |=> filter_accept_enable[0] == $past(reg_wdata[cfd_pkg::FLT_EN_POS]))
        else $error("enable bit not written");

    a_ptr_write: assert property (
        reg_wr && reg_addr == cfd_pkg::OFS_FLT0 && !en_reg[0]
        |=> filter_target_object[0] == $past(reg_wdata[cfd_pkg::PTR_W-1:0]))
        else $error("pointer not written while disabled");

    a_ptr_locked_hi: assert property (
        reg_wr && reg_addr == cfd_pkg::OFS_FLT1 && en_reg[NUM_FLT-1]
        |=> $stable(ptr_reg[NUM_FLT-1]))
        else $error("upper pointer changed while enabled");

    a_rdata_hold: assert property (
        !reg_rd
        |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    a_unmapped_zero: assert property (
        reg_rd && reg_addr != cfd_pkg::OFS_DIAG && reg_addr != cfd_pkg::OFS_FLT0
        && reg_addr != cfd_pkg::OFS_FLT1 |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read nonzero");
endmodule

// ---- core/cfd_pkg.sv ----
// Purpose: Shared constants and carriers for the bus diagnostics and filter map
// Assumes: 32-bit register port, one aligned word per register
// Notes: Flag positions are bit numbers of the diagnostics word
package cfd_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_DIAG = 8'h00;
    localparam logic [7:0] OFS_FLT0 = 8'h04;
    localparam logic [7:0] OFS_FLT1 = 8'h08;
    localparam logic [31:0] DIAG_RESET = 32'h0000_0000;
    localparam logic [31:0] FLT_RESET = 32'h0000_0000;
    localparam int POS_LEN_MISMATCH = 31;
    localparam int POS_ESI = 30;
    localparam int POS_DATA_CRC = 29;
    localparam int POS_DATA_STUFF = 28;
    localparam int POS_DATA_FORM = 27;
    localparam int POS_DATA_REC = 25;
    localparam int POS_DATA_DOM = 24;
    localparam int POS_TX_BUSOFF = 23;
    localparam int POS_NOM_CRC = 21;
    localparam int POS_NOM_STUFF = 20;
    localparam int POS_NOM_FORM = 19;
    localparam int POS_ACK = 18;
    localparam int POS_NOM_REC = 17;
    localparam int POS_NOM_DOM = 16;
    localparam logic [15:0] FLAG_MASK = 16'hfbbf;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [3:0] RECOV_RUN = 4'hb;
    localparam int FLT_PER_REG = 4;
    localparam int FLT_EN_POS = 7;
    localparam int PTR_W = 5;

    typedef struct packed {
        logic length_code_mismatch;
        logic esi_received;
        logic data_crc_fail;
        logic data_stuffing_fail;
        logic data_form_fail;
        logic tx_busoff_recovered;
        logic nominal_crc_fail;
        logic nominal_stuffing_fail;
        logic nominal_form_fail;
        logic ack_missing;
        logic clean_message;
    } cfd_evt_t;

    typedef struct packed {
        logic bit_valid;
        logic tx_active;
        logic arbitration;
        logic data_phase;
        logic driven_level;
        logic sampled_level;
        logic busoff_recovery;
    } cfd_bit_t;
endpackage

// ---- verif/cfd_bus_model.sv ----
// Purpose: Far-side bus model driving bit observations and error events
// Assumes: Tasks are entered just after a rising mclk edge
// Notes: Stale observation lines show the inverse of the last bit; recovery level holds
`timescale 1ns/1ps
module cfd_bus_model (
    input wire logic mclk,
    output cfd_pkg::cfd_bit_t bit_obs,
    output cfd_pkg::cfd_evt_t err_evt
);
    initial begin
        bit_obs = '0;
        err_evt = '0;
    end
    // Fields: tx_active, arbitration, data_phase, driven, sampled, recovery
    task automatic send_bit(input logic [5:0] f);
        bit_obs <= {1'b1, f};
        @(posedge mclk);
        bit_obs <= {1'b0, ~f[5:1], f[0]};
        @(posedge mclk);
    endtask
    task automatic pulse(input cfd_pkg::cfd_evt_t e);
        err_evt <= e;
        @(posedge mclk);
        err_evt <= '0;
        @(posedge mclk);
    endtask
endmodule

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for diagnostics word and filter map
// Assumes: Register port with read data one cycle after the strobe
// Notes: Model holds expected register words and clears on diag access
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb;
    logic mclk, sys_rst, reg_wr, reg_rd;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, got, m_diag, wd;
    logic [31:0] m_flt [2];
    cfd_pkg::cfd_bit_t bit_obs;
    cfd_pkg::cfd_evt_t err_evt;
    logic [7:0] fen;
    logic [7:0][4:0] fptr;
    int n_mismatch, checks_done, cnt;
    int pos [10] = '{31, 30, 29, 28, 27, 23, 21, 20, 19, 18};
    logic [5:0] bf [5] = '{6'b100010, 6'b101010, 6'b100100, 6'b101100, 6'b110100};
    int bp [5] = '{16, 24, 17, 25, -1};
    cfd_diag_filter #(.NUM_FLT(8)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .bit_obs(bit_obs), .err_evt(err_evt),
        .filter_accept_enable(fen), .filter_target_object(fptr));
    cfd_bus_model u_bus (.mclk(mclk), .bit_obs(bit_obs), .err_evt(err_evt));
    initial begin
        mclk = 0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge mclk);
        reg_wr <= 0;
        @(posedge mclk);
        k = (a == 8'h08);
        if (a == 8'h00) m_diag = 0;
        else for (int l = 0; l < 4; l++) begin
            if (!m_flt[k][8*l+7]) m_flt[k][8*l+:5] = d[8*l+:5];
            m_flt[k][8*l+7] = d[8*l+7];
        end
    endtask
    task automatic chk_rd(input logic [7:0] a);
        logic [31:0] e;
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge mclk);
        reg_rd <= 0;
        #1 got = reg_rdata;
        e = (a == 0) ? m_diag : (a == 4) ? m_flt[0] : (a == 8) ? m_flt[1] : 0;
        `CHK("reg_rdata", e, got)
        if (a == 0) m_diag = 0;
        @(posedge mclk);
    endtask
    task automatic clean(input int n);
        repeat (n) begin
            u_bus.pulse(11'h001);
            if (m_diag[15:0] != 16'hffff) m_diag[15:0] = m_diag[15:0] + 16'h0001;
        end
    endtask
    task automatic conclude;
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        sys_rst = 1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {n_mismatch, checks_done, m_diag} = '0;
        m_flt = '{0, 0};
        void'($urandom(32'h8f19b5d3));
        repeat (5) @(posedge mclk);
        sys_rst <= 0;
        @(posedge mclk);
        for (int a = 0; a < 16; a += 4) chk_rd(8'(a));
        for (int i = 0; i < 10; i++) begin
            u_bus.pulse(11'(1) << (10 - i));
            m_diag[pos[i]] = 1;
            chk_rd(0);
            chk_rd(0);
        end
        wd = $urandom;
        u_bus.pulse(11'(wd) & 11'h7fe);
        for (int i = 0; i < 10; i++)
            if (wd[10 - i]) m_diag[pos[i]] = 1;
        chk_rd(0);
        for (int i = 0; i < 5; i++) begin
            u_bus.send_bit(bf[i]);
            if (bp[i] >= 0) m_diag[bp[i]] = 1;
            chk_rd(0);
        end
        u_bus.send_bit(6'b000101);
        repeat (10) u_bus.send_bit(6'b000111);
        chk_rd(0);
        u_bus.send_bit(6'b000111);
        m_diag[16] = 1;
        m_diag[24] = 1;
        chk_rd(0);
        for (int i = 0; i < 8; i++) begin
            wd = $urandom & 32'h0000_003e;
            u_bus.send_bit(wd[5:0]);
            if (wd[5] && !wd[2] && wd[1]) m_diag[wd[3] ? 24 : 16] = 1;
            if (wd[5] && !wd[4] && wd[2] && !wd[1]) m_diag[wd[3] ? 25 : 17] = 1;
            chk_rd(0);
        end
        clean(1 + $urandom % 40);
        chk_rd(0);
        chk_rd(0);
        clean(3);
        fork
            chk_rd(0);
            u_bus.pulse(11'h011);
        join
        m_diag = 32'h0020_0001;
        chk_rd(0);
        for (int j = 0; j < 12; j++) begin
            // Software never asks for object zero
            for (int l = 0; l < 4; l++)
                wd[8*l+:8] = {1'($urandom), 2'b11, 5'(1 + $urandom % 31)};
            wr(8'(4 + 4 * (j % 2)), wd);
            chk_rd(8'(4 + 4 * (j % 2)));
            for (int f = 0; f < 8; f++) begin
                `CHK("filter_accept_enable", m_flt[f/4][8*(f%4)+7], fen[f])
                `CHK("filter_target_object", m_flt[f/4][8*(f%4)+:5], fptr[f])
            end
        end
        u_bus.pulse(11'h7fe);
        sys_rst <= 1;
        repeat (5) @(posedge mclk);
        sys_rst <= 0;
        @(posedge mclk);
        m_diag = 0;
        m_flt = '{0, 0};
        `CHK("reg_rdata", 32'h0, reg_rdata)
        `CHK("filter_accept_enable", 8'h00, fen)
        `CHK("filter_target_object", 40'h0, fptr)
        chk_rd(4);
        chk_rd(0);
        u_bus.pulse(11'h040);
        wr(0, 32'hffff_ffff);
        chk_rd(0);
        conclude();
    end
endmodule
